// ==== include/dca_defines.svh ====
// Purpose: Register map, field positions and codes of the DMA block.
// Assumes: Byte addresses on an 8-bit AXI4-Lite address.
// Notes:   Channel c occupies byte addresses c*16 .. c*16+12.
`ifndef DCA_DEFINES_SVH
`define DCA_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DCA_OFS_CTRL   4'h0
`define DCA_OFS_MAR    4'h4
`define DCA_OFS_IOAR   4'h8
`define DCA_OFS_CNT    4'hC
`define DCA_OFS_STAT   8'h40
`define DCA_OFS_MASK   8'h44

// ****************************************************************
// Control register fields
// ****************************************************************
`define DCA_CTRL_EN    0
`define DCA_CTRL_WORD  1
`define DCA_CTRL_STEP  2
`define DCA_CTRL_DOWN  3
`define DCA_CTRL_BLOCK 4
`define DCA_CTRL_FALO  5
`define DCA_CTRL_FAHI  6
`define DCA_CTRL_BSIDE 7
`define DCA_CTRL_SELL  8
`define DCA_CTRL_SELH  10
`define DCA_CTRL_MODL  11
`define DCA_CTRL_MODH  12

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define DCA_CTRL_RST   13'h0000
`define DCA_ADDR_RST   24'h00_0000
`define DCA_IOAR_RST   8'h00
`define DCA_CNT_RST    16'h0000
`define DCA_STAT_RST   4'h0
`define DCA_IOAR_HI    16'hFFFF
`define DCA_CNT_LAST   16'h0001

// ****************************************************************
// Activation select codes
// ****************************************************************
`define DCA_SEL_BURST  3'h0
`define DCA_SEL_CSTEAL 3'h2
`define DCA_SEL_TXE    3'h4
`define DCA_SEL_RXF    3'h5
`define DCA_SEL_FALL   3'h6
`define DCA_SEL_LOW    3'h7
`define DCA_SEL_TMRMAX 3'h3

// ****************************************************************
// Bus responses
// ****************************************************************
`define DCA_RESP_OKAY  2'h0
`define DCA_RESP_SLV   2'h2

`endif

// ==== include/dca_pkg.sv ====
// Purpose: Types shared by the DMA block.
// Assumes: Nothing beyond the defines header.
// Notes:   Short-address modes follow a Gray path io, idle, repeat.
package dca_pkg;

  typedef enum logic [1:0] {
    dca_mode_io     = 2'b00,
    dca_mode_idle   = 2'b01,
    dca_mode_repeat = 2'b11
  } dca_mode_t;

  typedef logic [23:0] dca_addr_t;
  typedef logic [12:0] dca_ctrl_t;
  typedef logic [15:0] dca_cnt_t;

endpackage

// ==== logic/dca_dma_top.sv ====
// Purpose: Four-channel DMA activation and transfer-mode engine.
// Assumes: Timer and serial events are one-cycle pulses on clk_i.
// Notes:   One transfer is issued per cycle on the xfer outputs.
//
// What this block does
// - Block mode with block-side bit 1 holds the source as block area.
// - Normal mode codes: 000 burst, 010 steal, 110 pin edge, 111 low.
// - Block mode codes 000-011 timers 0-3, 110 pin edge, rest unused.
// - One internal source may trigger several channels at once.
// - Concurrent channels are served in fixed priority, lowest index first.
// - Full address mode pairs A and B into one of two channels.
// - Short channels take timers 0-3 and serial transmit and receive.
// - I/O mode moves one unit per request, 24-bit and 8-bit addresses.
// - Short-mode direction comes from the activation source.
// - Completion in I/O, idle or normal mode can raise an interrupt.
// - Idle mode keeps both addresses fixed.
// - Repeat mode reloads address and count and keeps running.
// - Repeat mode never raises an interrupt.
// - Normal auto-request starts on enable and runs until count ends.
// - Normal auto-request uses 24-bit source and destination.
// - Full address mode needs both A-side select bits set.
// - Count drops by one per transfer; reaching zero clears enable.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "dca_defines.svh"

module dca_dma_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [3:0]  tmr_match_i,
  input  wire logic        ser_tx_empty_i,
  input  wire logic        ser_rx_full_i,
  input  wire logic [1:0]  ext_xfer_req_n_i,
  output logic             xfer_valid_o,
  output logic [23:0]      xfer_src_o,
  output logic [23:0]      xfer_dst_o,
  output logic             xfer_word_o,
  output logic [1:0]       xfer_chan_o,
  output logic             irq_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [31:0] dca_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic dca_code_ok(input logic [2:0] sel,
                                       input logic       full,
                                       input logic       block,
                                       input logic       isb);
    if (full && !block)
      return (sel == `DCA_SEL_BURST) || (sel == `DCA_SEL_CSTEAL) ||
             (sel == `DCA_SEL_FALL) || (sel == `DCA_SEL_LOW);
    else if (full)
      return (sel <= `DCA_SEL_TMRMAX) || (sel == `DCA_SEL_FALL);
    else
      return (sel <= `DCA_SEL_RXF) || ((sel == `DCA_SEL_FALL) && isb);
  endfunction

  function automatic dca_pkg::dca_addr_t dca_step(
      input dca_pkg::dca_addr_t a, input dca_pkg::dca_ctrl_t c,
      input logic word);
    dca_pkg::dca_addr_t d;
    d = word ? 24'h00_0002 : 24'h00_0001;
    if (!c[`DCA_CTRL_STEP])
      return a;
    return c[`DCA_CTRL_DOWN] ? a - d : a + d;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  dca_pkg::dca_ctrl_t ctrl_q [4];
  dca_pkg::dca_addr_t mar_q  [4];
  dca_pkg::dca_addr_t mar0_q [4];
  dca_pkg::dca_addr_t mar_nx [4];
  logic [7:0]         ioar_q [4];
  dca_pkg::dca_cnt_t  cnt_q  [4];
  dca_pkg::dca_cnt_t  cnt0_q [4];
  logic [3:0]         pend_q;
  logic [3:0]         stat_q;
  logic [3:0]         mask_q;
  logic [1:0]         ext_s1_q;
  logic [1:0]         ext_s2_q;
  logic [1:0]         ext_s3_q;
  logic               aw_have_q;
  logic [7:0]         aw_addr_q;
  logic               w_have_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  logic [3:0]         req_v;
  logic [3:0]         edge_v;
  logic [3:0]         ok_v;
  logic [3:0]         grant_oh;
  logic [3:0]         done_oh;
  logic [3:0]         sw_wr_ch;
  logic [1:0]         full_v;
  logic [1:0]         g;
  logic               grant_v;
  logic               g_rep;
  logic               g_full;
  logic               g_word;
  dca_pkg::dca_addr_t xs;
  dca_pkg::dca_addr_t xd;
  logic               wr_fire;
  logic               wr_ok;
  logic [31:0]        rd_v;
  logic               rd_ok;

  // ****************************************************************
  // Request pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_s1_q <= 2'h3;
      ext_s2_q <= 2'h3;
      ext_s3_q <= 2'h3;
    end
    else
    begin
      ext_s1_q <= ext_xfer_req_n_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // ****************************************************************
  // Activation decode
  // ****************************************************************
  for (genvar k = 0; k < 2; k++)
  begin : g_pair
    assign full_v[k] = ctrl_q[2*k][`DCA_CTRL_FAHI] &&
                       ctrl_q[2*k][`DCA_CTRL_FALO];
  end

  for (genvar c = 0; c < 4; c++)
  begin : g_act
    localparam int P = c / 2;
    logic [2:0] sel;
    logic       blk;
    logic       fl;
    logic       lvl;
    logic       en;
    assign sel = ctrl_q[c][`DCA_CTRL_SELH:`DCA_CTRL_SELL];
    assign fl  = full_v[P];
    assign blk = fl && ctrl_q[c][`DCA_CTRL_BLOCK];
    assign en  = ctrl_q[c][`DCA_CTRL_EN] && !(fl && (c % 2 == 1));
    assign ok_v[c] = dca_code_ok(sel, fl, blk, c % 2 == 1);
    // Each channel looks at the shared sources on its own.
    always_comb
    begin
      edge_v[c] = 1'b0;
      if (sel <= `DCA_SEL_TMRMAX && !(fl && !blk))
        edge_v[c] = tmr_match_i[sel[1:0]];
      else if (sel == `DCA_SEL_TXE && !fl)
        edge_v[c] = ser_tx_empty_i;
      else if (sel == `DCA_SEL_RXF && !fl)
        edge_v[c] = ser_rx_full_i;
      else if (sel == `DCA_SEL_FALL)
        edge_v[c] = ext_s3_q[P] && !ext_s2_q[P];
      edge_v[c] = edge_v[c] && ok_v[c];
    end
    // Pin-low activation trusts the requester to release the pin.
    assign lvl = fl && !blk && ((sel == `DCA_SEL_BURST) ||
                 (sel == `DCA_SEL_CSTEAL) ||
                 ((sel == `DCA_SEL_LOW) && !ext_s2_q[P]));
    assign req_v[c] = en && ok_v[c] && (pend_q[c] || lvl);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pend_q <= 4'h0;
    else
      pend_q <= ((pend_q & ~grant_oh) | edge_v) & req_en(ctrl_q);
  end

  function automatic logic [3:0] req_en(input dca_pkg::dca_ctrl_t c [4]);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 4; i++)
      r[i] = c[i][`DCA_CTRL_EN];
    return r;
  endfunction

  // ****************************************************************
  // Arbitration and address generation
  // ****************************************************************
  assign grant_oh = req_v & (~req_v + 4'h1);
  assign grant_v  = |req_v;
  assign g        = grant_oh[1] ? 2'd1 : grant_oh[2] ? 2'd2 :
                    grant_oh[3] ? 2'd3 : 2'd0;
  assign g_full   = full_v[g[1]];
  assign g_word   = ctrl_q[g][`DCA_CTRL_WORD];
  assign g_rep    = !g_full && (ctrl_q[g][`DCA_CTRL_MODH:`DCA_CTRL_MODL] ==
                    dca_pkg::dca_mode_repeat);
  assign done_oh  = grant_oh & {4{cnt_q[g] == `DCA_CNT_LAST}};

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      mar_nx[i] = mar_q[i];
    xs = mar_q[g];
    xd = mar_q[g];
    if (g_full)
    begin
      xs = mar_q[{g[1], 1'b0}];
      xd = mar_q[{g[1], 1'b1}];
      if (!(ctrl_q[g][`DCA_CTRL_BLOCK] && ctrl_q[g][`DCA_CTRL_BSIDE]))
        mar_nx[{g[1], 1'b0}] = dca_step(xs, ctrl_q[g], g_word);
      if (!(ctrl_q[g][`DCA_CTRL_BLOCK] && !ctrl_q[g][`DCA_CTRL_BSIDE]))
        mar_nx[{g[1], 1'b1}] = dca_step(xd, ctrl_q[{g[1], 1'b1}], g_word);
    end
    else
    begin
      if (ctrl_q[g][`DCA_CTRL_SELH:`DCA_CTRL_SELL] == `DCA_SEL_RXF)
        xs = {`DCA_IOAR_HI, ioar_q[g]};
      else
        xd = {`DCA_IOAR_HI, ioar_q[g]};
      if (ctrl_q[g][`DCA_CTRL_MODH:`DCA_CTRL_MODL] != dca_pkg::dca_mode_idle)
        mar_nx[g] = dca_step(mar_q[g], ctrl_q[g], g_word);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      xfer_valid_o <= 1'b0;
      xfer_src_o   <= `DCA_ADDR_RST;
      xfer_dst_o   <= `DCA_ADDR_RST;
      xfer_word_o  <= 1'b0;
      xfer_chan_o  <= 2'd0;
    end
    else
    begin
      xfer_valid_o <= grant_v;
      xfer_src_o   <= xs;
      xfer_dst_o   <= xd;
      xfer_word_o  <= g_word;
      xfer_chan_o  <= g;
    end
  end

  // ****************************************************************
  // Channel registers
  // ****************************************************************
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;
  assign wr_ok   = ((aw_addr_q[7:6] == 2'b00) && (aw_addr_q[1:0] == 2'b00))
                   || (aw_addr_q == `DCA_OFS_STAT)
                   || (aw_addr_q == `DCA_OFS_MASK);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < 4; c++)
      begin
        ctrl_q[c] <= `DCA_CTRL_RST;
        mar_q[c]  <= `DCA_ADDR_RST;
        mar0_q[c] <= `DCA_ADDR_RST;
        ioar_q[c] <= `DCA_IOAR_RST;
        cnt_q[c]  <= `DCA_CNT_RST;
        cnt0_q[c] <= `DCA_CNT_RST;
      end
    end
    else
    begin
      for (int c = 0; c < 4; c++)
      begin
        mar_q[c] <= mar_nx[c];
        if (grant_oh[c] && done_oh[c] && g_rep)
        begin
          mar_q[c] <= mar0_q[c];
          cnt_q[c] <= cnt0_q[c];
        end
        else if (grant_oh[c])
          cnt_q[c] <= cnt_q[c] - 16'h0001;
        if (done_oh[c] && !g_rep)
          ctrl_q[c][`DCA_CTRL_EN] <= 1'b0;
        // A software write lands after the engine update and wins.
        if (sw_wr_ch[c] && aw_addr_q[3:0] == `DCA_OFS_CTRL)
          ctrl_q[c] <= 13'(dca_merge(32'(ctrl_q[c]), w_data_q, w_strb_q));
        if (sw_wr_ch[c] && aw_addr_q[3:0] == `DCA_OFS_MAR)
        begin
          mar_q[c]  <= 24'(dca_merge(32'(mar_q[c]), w_data_q, w_strb_q));
          mar0_q[c] <= 24'(dca_merge(32'(mar_q[c]), w_data_q, w_strb_q));
        end
        if (sw_wr_ch[c] && aw_addr_q[3:0] == `DCA_OFS_IOAR)
          ioar_q[c] <= 8'(dca_merge(32'(ioar_q[c]), w_data_q, w_strb_q));
        if (sw_wr_ch[c] && aw_addr_q[3:0] == `DCA_OFS_CNT)
        begin
          cnt_q[c]  <= 16'(dca_merge(32'(cnt_q[c]), w_data_q, w_strb_q));
          cnt0_q[c] <= 16'(dca_merge(32'(cnt_q[c]), w_data_q, w_strb_q));
        end
      end
    end
  end

  for (genvar c = 0; c < 4; c++)
  begin : g_wr
    assign sw_wr_ch[c] = wr_fire && (aw_addr_q[7:4] == 4'(c)) &&
                         (aw_addr_q[1:0] == 2'b00);
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat_q <= `DCA_STAT_RST;
      mask_q <= `DCA_STAT_RST;
      irq_o  <= 1'b0;
    end
    else
    begin
      // New completions win over a clear in the same cycle.
      if (wr_fire && aw_addr_q == `DCA_OFS_STAT && w_strb_q[0])
        stat_q <= (stat_q & ~w_data_q[3:0]) |
                  (done_oh & {4{!g_rep}});
      else
        stat_q <= stat_q | (done_oh & {4{!g_rep}});
      if (wr_fire && aw_addr_q == `DCA_OFS_MASK && w_strb_q[0])
        mask_q <= w_data_q[3:0];
      irq_o <= |(stat_q & mask_q);
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_have_q       <= 1'b0;
      aw_addr_q       <= 8'h00;
      s_axi_awready_o <= 1'b1;
      w_have_q        <= 1'b0;
      w_data_q        <= 32'h0000_0000;
      w_strb_q        <= 4'h0;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `DCA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_q       <= 1'b1;
        aw_addr_q       <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_have_q       <= 1'b1;
        w_data_q       <= s_axi_wdata_i;
        w_strb_q       <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_q       <= 1'b0;
        w_have_q        <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
        s_axi_bvalid_o  <= 1'b1;
        s_axi_bresp_o   <= wr_ok ? `DCA_RESP_OKAY : `DCA_RESP_SLV;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  always_comb
  begin
    rd_v  = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr_i == `DCA_OFS_STAT)
      rd_v = 32'(stat_q);
    else if (s_axi_araddr_i == `DCA_OFS_MASK)
      rd_v = 32'(mask_q);
    else if (s_axi_araddr_i[7:6] != 2'b00 || s_axi_araddr_i[1:0] != 2'b00)
      rd_ok = 1'b0;
    else if (s_axi_araddr_i[3:0] == `DCA_OFS_CTRL)
      rd_v = 32'(ctrl_q[s_axi_araddr_i[5:4]]);
    else if (s_axi_araddr_i[3:0] == `DCA_OFS_MAR)
      rd_v = 32'(mar_q[s_axi_araddr_i[5:4]]);
    else if (s_axi_araddr_i[3:0] == `DCA_OFS_IOAR)
      rd_v = 32'(ioar_q[s_axi_araddr_i[5:4]]);
    else
      rd_v = 32'(cnt_q[s_axi_araddr_i[5:4]]);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `DCA_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_v;
      s_axi_rresp_o   <= rd_ok ? `DCA_RESP_OKAY : `DCA_RESP_SLV;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_fixed_prio: assert property (
    grant_v |-> ((req_v & (grant_oh - 4'h1)) == 4'h0) && $onehot(grant_oh))
    else $error("grant not on highest priority request");
  chk_xfer_issue: assert property (
    grant_v |=> xfer_valid_o && (xfer_chan_o == $past(g)))
    else $error("granted transfer not issued");
  chk_irq_follow: assert property (
    (|(stat_q & mask_q)) |=> irq_o)
    else $error("interrupt output missing");

  for (genvar c = 0; c < 4; c++)
  begin : g_chk
    chk_count_dec: assert property (
      grant_oh[c] && !done_oh[c] && !sw_wr_ch[c]
      |=> cnt_q[c] == $past(cnt_q[c]) - 16'h0001)
      else $error("count did not drop by one");
    chk_end_clear: assert property (
      done_oh[c] && !g_rep && !sw_wr_ch[c] |=> !ctrl_q[c][`DCA_CTRL_EN])
      else $error("enable not cleared at end");
    chk_done_irq: assert property (
      done_oh[c] && !g_rep |=> stat_q[c])
      else $error("completion status not set");
    chk_repeat_reload: assert property (
      done_oh[c] && g_rep && !sw_wr_ch[c]
      |=> cnt_q[c] == cnt0_q[c] && mar_q[c] == mar0_q[c] &&
          ctrl_q[c][`DCA_CTRL_EN])
      else $error("repeat reload failed");
    chk_repeat_quiet: assert property (
      grant_oh[c] && g_rep && !stat_q[c] && !($past(done_oh[c]))
      |=> !stat_q[c])
      else $error("repeat mode raised status");
    chk_idle_hold: assert property (
      grant_oh[c] && !full_v[c/2] && !sw_wr_ch[c] &&
      ctrl_q[c][`DCA_CTRL_MODH:`DCA_CTRL_MODL] == dca_pkg::dca_mode_idle
      |=> $stable(mar_q[c]))
      else $error("idle mode moved address");
    chk_unusable_code: assert property (
      !ok_v[c] |-> !req_v[c] && !edge_v[c])
      else $error("unusable code produced a request");
  end

  cov_repeat_wrap: cover property (done_oh != 4'h0 && g_rep);
  cov_full_xfer: cover property (grant_v && g_full);
  cov_irq_rise: cover property (!irq_o ##1 irq_o);
  cov_two_req: cover property ($countones(req_v) > 1);

endmodule

// ==== tb/dca_req_model.sv ====
// Purpose: Far-side event sources and request pins for the DMA block.
// Assumes: Events are one-cycle pulses on the bench clock.
// Notes:   Request pins rest released until a test pulls one low.
`timescale 1ns/1ns
module dca_req_model (
  input  wire logic       clk_i,
  output logic [3:0]      tmr_match_o,
  output logic            ser_tx_empty_o,
  output logic            ser_rx_full_o,
  output logic [1:0]      ext_xfer_req_n_o
);
  // ****************************************************************
  // Event pulses
  // ****************************************************************
  logic [5:0] ev_q = 6'h00;
  logic [1:0] pin_q = 2'h3;
  assign tmr_match_o      = ev_q[3:0];
  assign ser_tx_empty_o   = ev_q[4];
  assign ser_rx_full_o    = ev_q[5];
  // Released pins rest at their pull-up level, so nothing is requested.
  assign ext_xfer_req_n_o = pin_q;
  task automatic pin(input logic [1:0] v);
    @(posedge clk_i);
    pin_q <= v;
  endtask
  task automatic pulse(input logic [5:0] ev);
    @(posedge clk_i);
    ev_q <= ev;
    @(posedge clk_i);
    ev_q <= 6'h00;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the DMA activation engine.
// Assumes: bready and rready are held high throughout.
// Notes:   Transfers are logged by a monitor as they appear.
`timescale 1ns/1ns
module tb_top;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic [1:0] s;} dca_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, seq = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, xv, xw, irq, tx, rx;
  logic [1:0]  bresp, rresp, xc, pins, r, lc;
  logic [23:0] xs, xd, ls, ld;
  logic [3:0]  tmr;
  int          mismatches = 0, checked = 0, nx = 0;
  dca_row_t    rows [6] = '{'{8'h10, 32'h0000_FE00, 32'h0000_1E00, 2'h0},
    '{8'h14, 32'hFFFF_FFFF, 32'h00FF_FFFF, 2'h0},
    '{8'h18, 32'hFFFF_FFFF, 32'h0000_00FF, 2'h0},
    '{8'h1C, 32'hFFFF_FFFF, 32'h0000_FFFF, 2'h0},
    '{8'h44, 32'hFFFF_FFFF, 32'h0000_000F, 2'h0},
    '{8'h50, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2}};
  dca_dma_top DUT (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .tmr_match_i(tmr), .ser_tx_empty_i(tx),
    .ser_rx_full_i(rx), .ext_xfer_req_n_i(pins), .xfer_valid_o(xv),
    .xfer_src_o(xs), .xfer_dst_o(xd), .xfer_word_o(xw), .xfer_chan_o(xc),
    .irq_o(irq));
  dca_req_model U_MDL (.clk_i(clk_i), .tmr_match_o(tmr), .ser_tx_empty_o(tx),
    .ser_rx_full_o(rx), .ext_xfer_req_n_o(pins));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (xv === 1'b1)
    begin
      nx++;
      {lc, ls, ld} = {xc, xs, xd};
      seq = {seq[5:0], xc};
    end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk_i);
    {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'b11};
    while (!(da && dw))
    begin
      @(posedge clk_i);
      da = da || awready;
      dw = dw || wready;
      awvalid <= !da;
      wvalid  <= !dw;
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    {araddr, arvalid} <= {a, 1'b1};
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
  endtask
  task automatic wait_x(input int n);
    for (int i = 0; i < 60 && nx < n; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic final_report;
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    final_report();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({awready, wready, arready, bvalid, rvalid, xv, irq}, 7'h70);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      chk(r, rows[i].s);
      rd(rows[i].a);
      chk({r, d}, {rows[i].s, rows[i].r});
    end
    // Full address pair 0, normal auto-request, two transfers.
    wr(8'h04, 32'h0012_3456);
    wr(8'h14, 32'h00AB_CDEF);
    wr(8'h10, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0002);
    nx = 0;
    wr(8'h00, 32'h0000_0061);
    wait_x(2);
    chk(nx, 2);
    chk({lc, ls, ld}, {2'h0, 24'h12_3456, 24'hAB_CDEF});
    chk(irq, 1'b1);
    rd(8'h00);
    chk(d, 32'h0000_0060);
    wr(8'h40, 32'h0000_000F);
    // Idle channel 2 and I/O channel 3 share timer 1.
    wr(8'h24, 32'h0000_1000);
    wr(8'h28, 32'h0000_0055);
    wr(8'h2C, 32'h0000_0003);
    wr(8'h34, 32'h0000_2000);
    wr(8'h38, 32'h0000_0066);
    wr(8'h3C, 32'h0000_0001);
    wr(8'h30, 32'h0000_0101);
    nx = 0;
    wr(8'h20, 32'h0000_0905);
    repeat (3) U_MDL.pulse(6'h02);
    wait_x(4);
    chk(seq, 8'hBA);
    chk({lc, ls, ld}, {2'h2, 24'h00_1000, 24'hFF_FF55});
    chk(irq, 1'b1);
    wr(8'h40, 32'h0000_000F);
    // Receive-full turns the direction round.
    wr(8'h3C, 32'h0000_0001);
    wr(8'h30, 32'h0000_0501);
    U_MDL.pulse(6'h20);
    wait_x(5);
    chk({lc, ls, ld}, {2'h3, 24'hFF_FF66, 24'h00_2000});
    wr(8'h40, 32'h0000_000F);
    // Repeat mode reloads after two transfers and stays quiet.
    wr(8'h24, 32'h0000_1000);
    wr(8'h2C, 32'h0000_0002);
    nx = 0;
    wr(8'h20, 32'h0000_1905);
    repeat (3) U_MDL.pulse(6'h02);
    wait_x(3);
    chk({nx[1:0], ls}, {2'h3, 24'h00_1000});
    chk(irq, 1'b0);
    rd(8'h20);
    chk(d, 32'h0000_1905);
    // Pin level on pair 1, then pin edge on pair 0.
    wr(8'h2C, 32'h0000_0002);
    wr(8'h20, 32'h0000_0761);
    nx = 0;
    U_MDL.pin(2'h1);
    wait_x(2);
    U_MDL.pin(2'h3);
    chk(nx, 2);
    wr(8'h1C, 32'h0000_0001);
    wr(8'h10, 32'h0000_0601);
    wr(8'h00, 32'h0000_0601);
    nx = 0;
    U_MDL.pin(2'h2);
    wait_x(1);
    chk(nx, 1);
    chk({lc, ls, ld}, {2'h1, 24'hAB_CDEF, 24'hFF_FFFF});
    final_report();
  end
endmodule
